// file: rtl/rfia_top.sv
// Interrupt aggregator of a sub-GHz radio: flags, enables, status commands.
`timescale 1ns/100ps
`default_nettype none

`include "rfia_consts.svh"

module rfia_top (
   input  wire logic              I_CLOCK,
   input  wire logic              I_RST_B,
   input  wire rfia_pkg::rfia_grp_t I_EVENT,
   input  wire rfia_pkg::rfia_grp_t I_STATE,
   input  wire logic              I_CMD_VALID,
   input  wire logic [7:0]        I_CMD_CODE,
   input  wire logic [15:0]       I_CMD_PROP,
   input  wire logic [7:0]        I_CMD_WDATA,
   output logic                   O_IRQ_N,
   output logic [7:0]             O_QUICK_STAT,
   output logic                   O_RSP_VALID,
   output rfia_pkg::rfia_rsp_t    O_RSP
);

   // Which groups a status command answers and clears; zero for others.
   function automatic logic [2:0] status_mask(input logic [7:0] code);
      logic [2:0] m;
      m = 3'b000;
      unique case (code)
         `RFIA_CMD_GET_ALL:   m = 3'b111;
         `RFIA_CMD_GET_PKT:   m = 3'b001;
         `RFIA_CMD_GET_DEMOD: m = 3'b010;
         `RFIA_CMD_GET_COND:  m = 3'b100;
         default:             m = 3'b000;
      endcase
      return m;
   endfunction : status_mask

   // Property number to a one-hot select of the four enable properties.
   function automatic logic [3:0] prop_sel(input logic [15:0] prop);
      logic [3:0] s;
      s = 4'b0000;
      unique case (prop)
         `RFIA_PROP_GROUP_EN: s = 4'b0001;
         `RFIA_PROP_PKT_EN:   s = 4'b0010;
         `RFIA_PROP_DEMOD_EN: s = 4'b0100;
         `RFIA_PROP_COND_EN:  s = 4'b1000;
         default:             s = 4'b0000;
      endcase
      return s;
   endfunction : prop_sel

   logic [7:0]       group_en_q;
   logic [2:0][7:0]  irq_en_q;
   logic [2:0][7:0]  events;
   logic [2:0][7:0]  states;
   logic [2:0][7:0]  pend;
   logic [2:0]       req;
   logic [2:0]       clr_mask;
   logic [3:0]       sel;
   logic             is_set;
   logic             is_get;
   logic             is_status;
   logic             bad_cmd;
   logic [7:0]       prop_rd;
   logic [2:0][7:0]  pend_shown;
   logic [2:0][7:0]  stat_shown;
   rfia_pkg::rfia_rsp_t rsp_d;
   logic             irq_n_d;
   logic [7:0]       quick_d;

   // Group order inside the arrays follows the group index constants.
   assign events[`RFIA_GRP_PKT]   = I_EVENT.pkt;
   assign events[`RFIA_GRP_DEMOD] = I_EVENT.demod;
   assign events[`RFIA_GRP_COND]  = I_EVENT.cond;
   assign states[`RFIA_GRP_PKT]   = I_STATE.pkt;
   assign states[`RFIA_GRP_DEMOD] = I_STATE.demod;
   assign states[`RFIA_GRP_COND]  = I_STATE.cond;

   // Command decoding.
   assign is_status = I_CMD_VALID & (|status_mask(I_CMD_CODE));
   assign clr_mask  = I_CMD_VALID ? status_mask(I_CMD_CODE) : 3'b000;
   assign sel       = prop_sel(I_CMD_PROP);
   assign is_set    = I_CMD_VALID & (I_CMD_CODE == `RFIA_CMD_SET_PROP);
   assign is_get    = I_CMD_VALID & (I_CMD_CODE == `RFIA_CMD_GET_PROP);
   assign bad_cmd   = I_CMD_VALID & ~is_status
                      & ~((is_set | is_get) & (|sel));

   // Property read-back mux.
   assign prop_rd = ({8{sel[0]}} & group_en_q)
                  | ({8{sel[1]}} & irq_en_q[`RFIA_GRP_PKT])
                  | ({8{sel[2]}} & irq_en_q[`RFIA_GRP_DEMOD])
                  | ({8{sel[3]}} & irq_en_q[`RFIA_GRP_COND]);

   // One flag group per interrupt group.
   genvar g;
   generate
      for (g = 0; g < `RFIA_NUM_GRP; g++) begin : gen_grp
         rfia_flag_group u_grp (
            .i_clk      (I_CLOCK),
            .i_rst_b    (I_RST_B),
            .i_event    (events[g]),
            .i_clear    (clr_mask[g]),
            .i_enable   (irq_en_q[g]),
            .i_group_en (group_en_q[g]),
            .o_pend     (pend[g]),
            .o_req      (req[g])
         );
         // Only answered groups show flags; live state follows them.
         assign pend_shown[g] = clr_mask[g] ? pend[g] : 8'h00;
         assign stat_shown[g] = clr_mask[g] ? states[g] : 8'h00;
      end
   endgenerate

   // Response contents.
   assign rsp_d.err        = bad_cmd;
   assign rsp_d.prop_data  = is_get ? prop_rd : 8'h00;
   assign rsp_d.pkt_pend   = pend_shown[`RFIA_GRP_PKT];
   assign rsp_d.pkt_stat   = stat_shown[`RFIA_GRP_PKT];
   assign rsp_d.demod_pend = pend_shown[`RFIA_GRP_DEMOD];
   assign rsp_d.demod_stat = stat_shown[`RFIA_GRP_DEMOD];
   assign rsp_d.cond_pend  = pend_shown[`RFIA_GRP_COND];
   assign rsp_d.cond_stat  = stat_shown[`RFIA_GRP_COND];

   // Request pin and quick status follow the flags one cycle later.
   assign irq_n_d = ~(|req);
   assign quick_d = {5'h00, |pend[2], |pend[1], |pend[0]};

   // Enable properties.
   always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         group_en_q                  <= `RFIA_RST_GROUP_EN;
         irq_en_q[`RFIA_GRP_PKT]     <= `RFIA_RST_PKT_EN;
         irq_en_q[`RFIA_GRP_DEMOD]   <= `RFIA_RST_DEMOD_EN;
         irq_en_q[`RFIA_GRP_COND]    <= `RFIA_RST_COND_EN;
      end else if (is_set) begin
         if (sel[0]) group_en_q <= I_CMD_WDATA;
         if (sel[1]) irq_en_q[`RFIA_GRP_PKT] <= I_CMD_WDATA;
         if (sel[2]) irq_en_q[`RFIA_GRP_DEMOD] <= I_CMD_WDATA;
         if (sel[3]) irq_en_q[`RFIA_GRP_COND] <= I_CMD_WDATA;
      end
   end

   // Output flip-flops.
   always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_IRQ_N      <= 1'b1;
         O_QUICK_STAT <= 8'h00;
         O_RSP_VALID  <= 1'b0;
         O_RSP        <= '0;
      end else begin
         O_IRQ_N      <= irq_n_d;
         O_QUICK_STAT <= quick_d;
         O_RSP_VALID  <= I_CMD_VALID;
         O_RSP        <= rsp_d;
      end
   end

   // Checks kept next to the logic they guard.

   a_irq_follows: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_B)
      (|req) |=> !O_IRQ_N)
      else $error("Request output did not fall for an enabled flag.");

   a_irq_deadline: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_B)
      $rose(|I_EVENT) ##0 (group_en_q[2] && |(I_EVENT.cond & irq_en_q[2]))
      |-> ##[1:2] !O_IRQ_N)
      else $error("Request output missed its deadline.");

   // The pin answers a clear or an enable write one edge after the command edge.
   a_irq_holds: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_B)
      (!O_IRQ_N && !$past(is_status) && !$past(is_set)) |=> !O_IRQ_N)
      else $error("Request output rose without a status read.");

   a_read_all_clears: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_B)
      (I_CMD_VALID && I_CMD_CODE == `RFIA_CMD_GET_ALL && events == '0
       && !$past(is_set))
      |=> (pend == '0) ##1 O_IRQ_N)
      else $error("Read-all did not clear and release.");

   a_group_only: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_B)
      (I_CMD_VALID && I_CMD_CODE == `RFIA_CMD_GET_PKT)
      |=> (pend[1] == ($past(pend[1]) | $past(events[1])))
          && O_RSP.demod_pend == 8'h00 && O_RSP_VALID)
      else $error("Group read touched another group.");

   a_rsp_content: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_B)
      (I_CMD_VALID && I_CMD_CODE == `RFIA_CMD_GET_ALL)
      |=> O_RSP.cond_pend == $past(pend[2])
          && O_RSP.cond_stat == $past(states[2]))
      else $error("Status answer differs from flags or state.");

   a_quick_no_clear: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_B)
      (!I_CMD_VALID) |=> ((pend & $past(pend)) == $past(pend)))
      else $error("Flags fell without a status command.");

   a_quick_deadline: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_B)
      (|I_EVENT.pkt) |-> ##[1:2] O_QUICK_STAT[0])
      else $error("Quick status missed its deadline.");

   a_prop_readback: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_B)
      (is_set && sel[0]) |=> group_en_q == $past(I_CMD_WDATA))
      else $error("Property write did not land.");

   a_prop_readout: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_B)
      (is_get && sel[1])
      |=> O_RSP.prop_data == $past(irq_en_q[`RFIA_GRP_PKT]))
      else $error("Property read-back differs from the stored value.");

   a_reset_enables: assert property (
      @(posedge I_CLOCK)
      $rose(I_RST_B) |-> group_en_q == 8'h04
                        && irq_en_q[0] == 8'h00 && irq_en_q[1] == 8'h00
                        && irq_en_q[2] == 8'h04)
      else $error("Enable properties have wrong reset values.");

   // All three groups are checked at once against the low three group-enable bits.
   a_gating: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_B)
      (req & ~group_en_q[2:0]) == 3'b000)
      else $error("Request raised by a disabled group.");

   a_stat_live: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_B)
      (I_CMD_VALID && I_CMD_CODE == `RFIA_CMD_GET_PKT)
      |=> O_RSP.pkt_stat == $past(states[`RFIA_GRP_PKT]))
      else $error("Packet status answer differs from live state.");

endmodule : rfia_top

`default_nettype wire

// file: rtl/rfia_consts.svh
// Constants for the radio interrupt aggregator: offsets, codes, resets, times.
`ifndef RFIA_CONSTS_SVH
`define RFIA_CONSTS_SVH

// Status command codes.
`define RFIA_CMD_GET_ALL    8'h20
`define RFIA_CMD_GET_PKT    8'h21
`define RFIA_CMD_GET_DEMOD  8'h22
`define RFIA_CMD_GET_COND   8'h23
// Property access command codes.
`define RFIA_CMD_SET_PROP   8'h11
`define RFIA_CMD_GET_PROP   8'h12

// Property numbers of the enable properties.
`define RFIA_PROP_GROUP_EN  16'h0100
`define RFIA_PROP_PKT_EN    16'h0101
`define RFIA_PROP_DEMOD_EN  16'h0102
`define RFIA_PROP_COND_EN   16'h0103

// Reset values of the enable properties.
`define RFIA_RST_GROUP_EN   8'h04
`define RFIA_RST_PKT_EN     8'h00
`define RFIA_RST_DEMOD_EN   8'h00
`define RFIA_RST_COND_EN    8'h04

// Group index, also the bit position inside the group-enable property.
`define RFIA_GRP_PKT        0
`define RFIA_GRP_DEMOD      1
`define RFIA_GRP_COND       2
`define RFIA_NUM_GRP        3

// Timing: clock rate and the two update deadlines after a state change.
`define RFIA_CLK_MHZ        250
`define RFIA_QUICK_US       5
`define RFIA_IRQ_US         13
`define RFIA_QUICK_CYC      (`RFIA_QUICK_US * `RFIA_CLK_MHZ)
`define RFIA_IRQ_CYC        (`RFIA_IRQ_US * `RFIA_CLK_MHZ)

`endif

// file: rtl/rfia_pkg.sv
// Types shared by the radio interrupt aggregator modules.
package rfia_pkg;

   // One byte per interrupt group.
   typedef struct packed {
      logic [7:0] cond;
      logic [7:0] demod;
      logic [7:0] pkt;
   } rfia_grp_t;

   // Answer to one command.
   typedef struct packed {
      logic       err;
      logic [7:0] prop_data;
      logic [7:0] pkt_pend;
      logic [7:0] pkt_stat;
      logic [7:0] demod_pend;
      logic [7:0] demod_stat;
      logic [7:0] cond_pend;
      logic [7:0] cond_stat;
   } rfia_rsp_t;

endpackage : rfia_pkg

// file: rtl/rfia_flag_group.sv
// Pending flags and request term of one interrupt group.
`timescale 1ns/100ps
`default_nettype none

module rfia_flag_group (
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic [7:0] i_event,
   input  wire logic       i_clear,
   input  wire logic [7:0] i_enable,
   input  wire logic       i_group_en,
   output logic      [7:0] o_pend,
   output logic            o_req
);

   logic [7:0] pend_q;
   logic [7:0] pend_d;

   // A clear drops the flags that were answered; new events still set.
   assign pend_d = i_clear ? i_event : (pend_q | i_event);
   // Each flag needs its own enable and the group enable.
   assign o_req  = i_group_en & (|(pend_q & i_enable));
   assign o_pend = pend_q;

   // Flag storage.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pend_q <= 8'h00;
      end else begin
         pend_q <= pend_d;
      end
   end

   a_event_kept: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_event != 8'h00) |=> ((o_pend & $past(i_event)) == $past(i_event)))
      else $error("An event was lost on a clear.");

   a_clear_drops: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_clear && i_event == 8'h00) |=> (o_pend == 8'h00))
      else $error("A clear did not drop the pending flags.");

endmodule : rfia_flag_group

`default_nettype wire

// file: tb/rfia_host_model.sv
// Host model that presents status and property commands to the block.
`timescale 1ns/100ps
`default_nettype none

module rfia_host_model (
   input  wire logic        i_clk,
   output logic             o_cmd_valid,
   output logic [7:0]       o_cmd_code,
   output logic [15:0]      o_cmd_prop,
   output logic [7:0]       o_cmd_wdata
);
   // The port starts idle with no command strobe.
   initial begin
      o_cmd_valid = 1'b0;
      o_cmd_code  = 8'h00;
      o_cmd_prop  = 16'h0000;
      o_cmd_wdata = 8'h00;
   end

   // One command for one edge; the fields are scrambled once released.
   task automatic send(input logic [7:0] code, input logic [15:0] prop,
                       input logic [7:0] wdata);
      @(posedge i_clk);
      #1;
      o_cmd_valid = 1'b1;
      o_cmd_code  = code;
      o_cmd_prop  = prop;
      o_cmd_wdata = wdata;
      @(posedge i_clk);
      #1;
      o_cmd_valid = 1'b0;
      o_cmd_code  = ~code;
      o_cmd_prop  = ~prop;
      o_cmd_wdata = ~wdata;
   endtask : send
endmodule : rfia_host_model
`default_nettype wire

// file: tb/rfia_top_tb.sv
// Self-checking bench of the radio interrupt aggregator.
`timescale 1ns/100ps
`default_nettype none

module rfia_top_tb;
   logic                clk;
   logic                rst_b;
   rfia_pkg::rfia_grp_t ev;
   rfia_pkg::rfia_grp_t st;
   logic                cmd_valid;
   logic [7:0]          cmd_code;
   logic [15:0]         cmd_prop;
   logic [7:0]          cmd_wdata;
   logic                irq_n;
   logic [7:0]          quick;
   logic                rsp_valid;
   rfia_pkg::rfia_rsp_t rsp;
   rfia_pkg::rfia_rsp_t exp_q[$];
   rfia_pkg::rfia_grp_t pd;
   logic [7:0]          en[4];
   logic [15:0]         lf;
   int                  fail_count;
   int                  check_count;
   int                  cyc = 0;

   rfia_top rfia_top_inst (.I_CLOCK(clk), .I_RST_B(rst_b), .I_EVENT(ev),
      .I_STATE(st), .I_CMD_VALID(cmd_valid), .I_CMD_CODE(cmd_code),
      .I_CMD_PROP(cmd_prop), .I_CMD_WDATA(cmd_wdata), .O_IRQ_N(irq_n),
      .O_QUICK_STAT(quick), .O_RSP_VALID(rsp_valid), .O_RSP(rsp));

   rfia_host_model rfia_host_model_inst (.i_clk(clk), .o_cmd_valid(cmd_valid),
      .o_cmd_code(cmd_code), .o_cmd_prop(cmd_prop), .o_cmd_wdata(cmd_wdata));

   // Compare tasks, one per kind of result.
   task automatic chk_rsp(input rfia_pkg::rfia_rsp_t e, s);
      check_count++;
      if (e !== s) begin
         fail_count++;
         $display("ERROR response exp %h got %h", e, s);
      end
   endtask : chk_rsp

   task automatic chk8(input string n, input logic [7:0] e, s);
      check_count++;
      if (e !== s) begin
         fail_count++;
         $display("ERROR %s exp %h got %h", n, e, s);
      end
   endtask : chk8

   task automatic final_report();
      if (exp_q.size() != 0) begin
         fail_count++;
         $display("ERROR response queue exp 0 got %0d", exp_q.size());
      end
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report

   // Sixteen-bit shift register that supplies the random values.
   function automatic logic [15:0] nxt(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : nxt

   // Request level expected from the flag and enable model.
   function automatic logic exp_irq_n();
      return !(((pd.pkt & en[1]) != 8'h00 && en[0][0]) ||
               ((pd.demod & en[2]) != 8'h00 && en[0][1]) ||
               ((pd.cond & en[3]) != 8'h00 && en[0][2]));
   endfunction : exp_irq_n

   // Notes the expected answer, drives command and events, checks outputs.
   task automatic step(input logic c, input logic [7:0] code,
         input logic [15:0] prop, input logic [7:0] wd,
         input rfia_pkg::rfia_grp_t e);
      rfia_pkg::rfia_rsp_t r;
      logic [2:0]          m;
      logic                pv;
      int                  i;
      r = '0;
      m = code == 8'h20 ? 3'b111 : code == 8'h21 ? 3'b001 :
          code == 8'h22 ? 3'b010 : code == 8'h23 ? 3'b100 : 3'b000;
      pv = prop >= 16'h0100 && prop <= 16'h0103;
      i = int'(prop[1:0]);
      lf = nxt(lf);
      if (c) begin
         r.err = m == 3'b000 && !((code == 8'h11 || code == 8'h12) && pv);
         r.pkt_pend = m[0] ? pd.pkt : 8'h00;
         r.pkt_stat = m[0] ? lf[7:0] : 8'h00;
         r.demod_pend = m[1] ? pd.demod : 8'h00;
         r.demod_stat = m[1] ? lf[15:8] : 8'h00;
         r.cond_pend = m[2] ? pd.cond : 8'h00;
         r.cond_stat = m[2] ? lf[11:4] : 8'h00;
         if (code == 8'h12 && pv) r.prop_data = en[i];
         if (code == 8'h11 && pv) en[i] = wd;
         pd = pd & ~{{8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
         exp_q.push_back(r);
      end
      // Events meet the command edge, so a clear and an event can coincide.
      pd = pd | e;
      fork
         if (c) rfia_host_model_inst.send(code, prop, wd);
         begin
            @(posedge clk);
            #1;
            ev = e;
            @(posedge clk);
            #1;
            ev = '0;
         end
      join
      @(posedge clk);
      #1;
      chk8("irq_n", {7'h00, exp_irq_n()}, {7'h00, irq_n});
      chk8("quick", {5'h00, pd.cond != 0, pd.demod != 0, pd.pkt != 0},
           quick);
   endtask : step

   // State and event lines meet the command edge of each step.
   always @(posedge clk) begin
      #1;
      st <= {lf[11:4], lf[15:8], lf[7:0]};
   end

   // Answer watcher: each answer takes the oldest note off the queue.
   always @(negedge clk) begin
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            fail_count++;
            $display("ERROR response exp none got %h", rsp);
         end else begin
            chk_rsp(exp_q.pop_front(), rsp);
         end
      end
   end

   // Clock and hang guard.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         final_report();
      end
   end

   initial begin
      rst_b = 1'b0;
      ev = '0;
      st = '0;
      pd = '0;
      lf = 16'd33820;
      en = '{8'h04, 8'h00, 8'h00, 8'h04};
      repeat (4) @(posedge clk);
      #1;
      rst_b = 1'b1;
      step(1, 8'h12, 16'h0100, 8'h00, '0);
      for (int p = 1; p < 4; p++) begin
         step(1, 8'h12, 16'h0100 | 16'(p), 8'h00, '0);
      end
      step(1, 8'h12, 16'h0104, 8'h00, '0);
      step(1, 8'h5A, 16'h0100, 8'h00, '0);
      step(0, 8'h00, 16'h0000, 8'h00, 24'h04_0000);
      step(0, 8'h00, 16'h0, 8'h00, '0);
      step(1, 8'h23, 16'h0, 8'h00, '0);
      step(0, 8'h00, 16'h0000, 8'h00, 24'h00_1008);
      step(1, 8'h11, 16'h0101, 8'h08, '0);
      step(1, 8'h11, 16'h0100, 8'h07, '0);
      step(1, 8'h12, 16'h0101, 8'h00, '0);
      step(1, 8'h21, 16'h0, 8'h00, '0);
      step(1, 8'h11, 16'h0102, 8'hFF, '0);
      step(1, 8'h20, 16'h0000, 8'h00, 24'h04_0000);
      step(1, 8'h20, 16'h0, 8'h00, '0);
      for (int k = 0; k < 40; k++) begin
         step(lf[0], {6'h08, lf[2:1]}, '0, '0, {lf, lf[7:0]});
      end
      final_report();
   end
endmodule : rfia_top_tb
`default_nettype wire
